// ### bench/testbench.sv
// Self-checking testbench of the wake-on-radio sleep timer.
`timescale 1ns/100ps
module testbench
    import wortc_pkg::*;
;
    typedef struct {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } wortc_row_s;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        primary_event;
    logic        secondary_event;
    logic        rc_osc_running;
    logic        rc_osc_cal_busy;
    int          errors;
    int          checks_done;

    wortc_top wortc_top_inst (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .primary_event   (primary_event),
        .secondary_event (secondary_event),
        .rc_osc_running  (rc_osc_running),
        .rc_osc_cal_busy (rc_osc_cal_busy)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // Comparison, bus and wait helpers
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_count(input string what, input int exp,
                               input int got);
        checks_done++;
        if (got != exp) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count

    // The request is held until pready is sampled high, then released.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check_word("pready", 32'h0000_0001, {31'h0, pready});
        if (pready !== 1'b1) begin
            close_out();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check_word(what, exp, rd);
    endtask : rd_chk

    // Counts edges until the chosen pulse is seen; other counts the
    // pulses of the opposite event on the way.
    task automatic wait_ev(input logic sec, input int bound, input logic must,
                           output int n, output int other);
        logic hit;
        n = 0;
        other = 0;
        hit = 1'b0;
        while (!hit && n < bound) begin
            @(posedge pclk);
            n++;
            hit = ((sec ? secondary_event : primary_event) === 1'b1);
            if ((sec ? primary_event : secondary_event) === 1'b1) begin
                other++;
            end
        end
        check_word("event seen", {31'h0, must}, {31'h0, hit});
        if (must && !hit) begin
            close_out();
        end
    endtask : wait_ev

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        check_word("outputs in reset", 32'h0000_0000,
                   {26'h0, pready, pslverr, primary_event, secondary_event,
                    rc_osc_running, rc_osc_cal_busy});
        presetn <= 1'b1;
    endtask : do_reset

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    wortc_row_s rows [10] = '{
        '{1'b1, ADDR_WAKE_HIGH, 32'hffff_ff3c, 32'h0000_0000, 1'b0},
        '{1'b0, ADDR_WAKE_HIGH, 32'h0000_0000, 32'h0000_003c, 1'b0},
        '{1'b1, ADDR_WAKE_LOW, 32'h0000_00c5, 32'h0000_0000, 1'b0},
        '{1'b0, ADDR_WAKE_LOW, 32'h0000_0000, 32'h0000_00c5, 1'b0},
        '{1'b1, ADDR_TIMER_CTRL, 32'h0000_00ff, 32'h0000_0000, 1'b0},
        '{1'b0, ADDR_TIMER_CTRL, 32'h0000_0000, 32'h0000_00fb, 1'b0},
        '{1'b1, ADDR_TIMER_CTRL, 32'h0000_0092, 32'h0000_0000, 1'b0},
        '{1'b0, ADDR_TIMER_CTRL, 32'h0000_0000, 32'h0000_0092, 1'b0},
        '{1'b1, 12'h100, 32'hffff_ffff, 32'h0000_0000, 1'b1},
        '{1'b0, 12'h100, 32'h0000_0000, 32'h0000_0000, 1'b1}
    };
    int sec_p [3] = '{4, 6, 8};

    initial begin
        logic [31:0] rd;
        logic        err;
        logic [2:0]  s;
        int          n;
        int          o;
        int          i;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        errors  = 0;
        checks_done = 0;
        do_reset();
        for (i = 0; i < 10; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, err);
            if (!rows[i].w) begin
                check_word("prdata", rows[i].x, rd);
            end
            check_word("pslverr", {31'h0, rows[i].e}, {31'h0, err});
        end
        $display("test register table done");
        // A second reset in mid-run must restore every field.
        do_reset();
        rd_chk("high reset", ADDR_WAKE_HIGH, 32'h0000_0087);
        rd_chk("low reset", ADDR_WAKE_LOW, 32'h0000_006b);
        rd_chk("ctrl reset", ADDR_TIMER_CTRL, 32'h0000_00f8);
        $display("test reset values done");
        wr(ADDR_WAKE_HIGH, 32'h0000_0000);
        wr(ADDR_WAKE_LOW, 32'h0000_0003);
        wr(ADDR_TIMER_CTRL, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        #1;
        check_word("running", 32'h1, {31'h0, rc_osc_running});
        @(posedge pclk);
        #1;
        check_word("cal busy", 32'h1, {31'h0, rc_osc_cal_busy});
        n = 0;
        while (rc_osc_cal_busy === 1'b1 && n < 8 * 750 + 20) begin
            @(posedge pclk);
            n++;
        end
        check_word("cal length", 32'h1,
                   {31'h0, (n >= 7 * 750 && n <= 8 * 750 + 10)});
        // Three periods never reach the four-period secondary delay, so
        // the timer sits in the secondary wait phase after its first event.
        rd_chk("status", ADDR_STATUS, 32'h0000_000b);
        $display("test power-up done");
        // Three periods are below the four-period secondary delay, so each
        // primary event restarts the wait and no secondary may show.
        wait_ev(1'b0, 3000, 1'b1, n, o);
        wait_ev(1'b0, 3000, 1'b1, n, o);
        check_count("primary interval", 3 * 750, n);
        check_count("secondary pulses", 0, o);
        for (i = 0; i < 3; i++) begin
            s = 3'(i);
            wr(ADDR_WAKE_LOW, 32'(sec_p[i] + 1));
            wr(ADDR_TIMER_CTRL, {24'h0, 1'b0, s, 4'h8});
            wait_ev(1'b0, (sec_p[i] + 2) * 750, 1'b1, n, o);
            wait_ev(1'b1, sec_p[i] * 750 + 10, 1'b1, n, o);
            check_count("secondary delay", sec_p[i] * 750, n);
        end
        $display("test event timing done");
        wr(ADDR_WAKE_LOW, 32'h0000_0003);
        wr(ADDR_TIMER_CTRL, 32'h0000_0088);
        repeat (4) @(posedge pclk);
        #1;
        check_word("running off", 32'h0, {31'h0, rc_osc_running});
        wait_ev(1'b0, 3000, 1'b0, n, o);
        $display("test power-down done");
        wr(ADDR_WAKE_LOW, 32'h0000_0001);
        wr(ADDR_TIMER_CTRL, 32'h0000_0009);
        wait_ev(1'b0, 25000, 1'b1, n, o);
        wait_ev(1'b0, 25000, 1'b1, n, o);
        check_count("coarse interval", 32 * 750, n);
        $display("test resolution done");
        close_out();
    end

endmodule : testbench

// ### rtl/wortc_event_timer.sv
// Primary and secondary event timer counted in RC periods.
`timescale 1ns/100ps
module wortc_event_timer
    import wortc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        tick,
    input  wire logic [15:0] period,
    input  wire logic [1:0]  res,
    input  wire logic [2:0]  sec_sel,
    output logic             primary_event,
    output logic             secondary_event,
    output logic [1:0]       phase
);

    typedef struct packed {
        wortc_phase_e ph;
        logic [14:0]  pre;
        logic [15:0]  cnt;
        logic [5:0]   sec;
        logic         ev0;
        logic         ev1;
    } wortc_tmr_s;

    wortc_tmr_s s_q;
    wortc_tmr_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.ev0 = 1'b0;
        s_d.ev1 = 1'b0;
        case (s_q.ph)
            T_OFF: begin
                if (run) begin
                    s_d.ph = T_PRI;
                end
            end
            T_PRI, T_SEC: begin
                if (tick && s_q.ph == T_SEC) begin
                    if (s_q.sec + 6'h01 == wortc_sec_periods(sec_sel)) begin
                        s_d.ev1 = 1'b1;
                        s_d.ph  = T_PRI;
                    end else begin
                        s_d.sec = s_q.sec + 6'h01;
                    end
                end
                // The primary count keeps running during the secondary
                // delay so the primary interval does not stretch.
                if (tick) begin
                    if (s_q.pre == wortc_step_last(res)) begin
                        s_d.pre = '0;
                        if (s_q.cnt + 16'h0001 == period) begin
                            s_d.cnt = '0;
                            s_d.ev0 = 1'b1;
                            s_d.sec = '0;
                            s_d.ph  = T_SEC;
                        end else begin
                            s_d.cnt = s_q.cnt + 16'h0001;
                        end
                    end else begin
                        s_d.pre = s_q.pre + 15'h0001;
                    end
                end
            end
            default: s_d.ph = T_OFF;
        endcase
        if (!run) begin
            s_d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign primary_event   = s_q.ev0;
    assign secondary_event = s_q.ev1;
    assign phase           = s_q.ph;

    // Helper: RC periods since the last primary event.
    logic [31:0] h_ticks_q;
    logic        h_seen_q;
    logic [31:0] h_want;
    assign h_want = {16'h0000, (period == 16'h0000) ? 16'hffff
                    : period - 16'h0001} * {17'h0_0000, wortc_step_last(res)}
                    + {16'h0000, (period == 16'h0000) ? 16'hffff
                    : period - 16'h0001} + {17'h0_0000, wortc_step_last(res)}
                    + 32'h0000_0001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_ticks_q <= '0;
            h_seen_q  <= 1'b0;
        end else begin
            h_ticks_q <= s_q.ev0 ? 32'h0000_0000 : h_ticks_q + {31'h0, tick};
            h_seen_q  <= run && (h_seen_q || s_q.ev0);
        end
    end

    prim_ival_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ev0 && h_seen_q && $stable(period) && $stable(res)
        |-> h_ticks_q == h_want)
        else $error("Primary interval differs from count times step");

    sec_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ev1 && $stable(sec_sel) && run
        |-> h_ticks_q == {26'h0, wortc_sec_periods(sec_sel)})
        else $error("Secondary delay differs from selected periods");

endmodule : wortc_event_timer

// ### rtl/wortc_pkg.sv
// Package of constants and helpers for the wake-on-radio sleep timer.
package wortc_pkg;

    // ------------------------------------------------------------------
    // Register indices, byte addresses and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_WAKE_HIGH  = 8'h1e;
    localparam logic [7:0]  IDX_WAKE_LOW   = 8'h1f;
    localparam logic [7:0]  IDX_TIMER_CTRL = 8'h20;
    localparam logic [7:0]  IDX_STATUS     = 8'h30;
    localparam logic [11:0] ADDR_WAKE_HIGH  = {2'h0, IDX_WAKE_HIGH, 2'h0};
    localparam logic [11:0] ADDR_WAKE_LOW   = {2'h0, IDX_WAKE_LOW, 2'h0};
    localparam logic [11:0] ADDR_TIMER_CTRL = {2'h0, IDX_TIMER_CTRL, 2'h0};
    localparam logic [11:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};

    localparam logic [7:0] RST_WAKE_HIGH = 8'h87;
    localparam logic [7:0] RST_WAKE_LOW  = 8'h6b;
    localparam logic       RST_RC_OSC_POWERDOWN     = 1'h1;
    localparam logic [2:0] RST_SEC_SEL   = 3'h7;
    localparam logic       RST_RC_OSC_CALIBRATE_ENABLE    = 1'h1;
    localparam logic [1:0] RST_RES       = 2'h0;

    // Field positions inside the timer control register.
    localparam int unsigned CTRL_PD_BIT  = 7;
    localparam int unsigned CTRL_SEC_LSB = 4;
    localparam int unsigned CTRL_CAL_BIT = 3;
    localparam int unsigned CTRL_RES_LSB = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // The reference clock stands in for the crystal; one RC period is
    // the reference period times this divisor.
    localparam int unsigned RC_DIV      = 750;
    localparam logic [9:0]  RC_DIV_LAST = 10'(RC_DIV - 1);
    // Last count of the automatic initial calibration, which spends eight RC periods.
    localparam logic [3:0]  CAL_LAST    = 4'h7;

    typedef enum logic [1:0] {
        T_OFF,
        T_PRI,
        T_SEC
    } wortc_phase_e;

    // Secondary delay in RC periods for each setting.
    function automatic logic [5:0] wortc_sec_periods(input logic [2:0] sel);
        case (sel)
            3'h0:    return 6'h04;
            3'h1:    return 6'h06;
            3'h2:    return 6'h08;
            3'h3:    return 6'h0c;
            3'h4:    return 6'h10;
            3'h5:    return 6'h18;
            3'h6:    return 6'h20;
            default: return 6'h30;
        endcase
    endfunction : wortc_sec_periods

    // Last prescaler value of one count step: 2^0, 2^5, 2^10, 2^15 periods.
    function automatic logic [14:0] wortc_step_last(input logic [1:0] res);
        case (res)
            2'h0:    return 15'h0000;
            2'h1:    return 15'h001f;
            2'h2:    return 15'h03ff;
            default: return 15'h7fff;
        endcase
    endfunction : wortc_step_last

endpackage : wortc_pkg

// ### rtl/wortc_rc_osc.sv
// RC oscillator model: period tick, power-down and initial calibration.
`timescale 1ns/100ps
module wortc_rc_osc
    import wortc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic powerdown,
    input  wire logic cal_enable,
    output logic      tick,
    output logic      running,
    output logic      cal_busy,
    output logic      cal_done
);

    typedef struct packed {
        logic [9:0] div;
        logic [3:0] cal_cnt;
        logic       running;
        logic       cal_busy;
        logic       cal_done;
        logic       tick;
    } wortc_osc_s;

    wortc_osc_s s_q;
    wortc_osc_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (powerdown) begin
            // Powering down forgets the calibration so the next
            // power-up calibrates again.
            s_d = '0;
        end else begin
            s_d.running = 1'b1;
            if (s_q.div == RC_DIV_LAST) begin
                s_d.div  = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.div = s_q.div + 10'h001;
            end
            s_d.cal_busy = cal_enable && !s_q.cal_done;
            if (s_q.cal_busy && s_q.tick) begin
                if (s_q.cal_cnt == CAL_LAST) begin
                    s_d.cal_done = 1'b1;
                    s_d.cal_busy = 1'b0;
                end else begin
                    s_d.cal_cnt = s_q.cal_cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick     = s_q.tick;
    assign running  = s_q.running;
    assign cal_busy = s_q.cal_busy;
    assign cal_done = s_q.cal_done;

    tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |-> s_q.div == 10'h000 ##1 !tick [*8])
        else $error("RC tick spacing too short");

    powerup_cal_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(powerdown) && cal_enable |-> ##2 cal_busy)
        else $error("Calibration did not start at power-up");

endmodule : wortc_rc_osc

// ### rtl/wortc_top.sv
// APB register file and top level of the wake-on-radio sleep timer.
//
// Summary of operation
// - High wake count byte, read/write, resets 0x87.
// - Low wake count byte, read/write, resets 0x6B.
// - Reset count gives about one second interval.
// - Timer clocked by RC oscillator, reference over 750.
// - Secondary delay select picks 4 to 48 periods.
// - Power-down resets 1; clearing starts calibration.
// - Calibration enable bit, resets to one.
// - Two-bit resolution field, resets to zero.
// - Step is 2^0, 2^5, 2^10, 2^15 periods.
// - Maximum timeout follows 65536 steps per setting.
// - All four resolutions accepted and honoured.
`timescale 1ns/100ps
module wortc_top
    import wortc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             primary_event,
    output logic             secondary_event,
    output logic             rc_osc_running,
    output logic             rc_osc_cal_busy
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  wake_high;
        logic [7:0]  wake_low;
        logic        rc_osc_powerdown;
        logic [2:0]  sec_sel;
        logic        rc_osc_calibrate_enable;
        logic [1:0]  res;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } wortc_regs_s;

    localparam wortc_regs_s REGS_RST = '{
        wake_high: RST_WAKE_HIGH,
        wake_low:  RST_WAKE_LOW,
        rc_osc_powerdown:     RST_RC_OSC_POWERDOWN,
        sec_sel:   RST_SEC_SEL,
        rc_osc_calibrate_enable:    RST_RC_OSC_CALIBRATE_ENABLE,
        res:       RST_RES,
        prdata:    32'h0000_0000,
        pready:    1'b0,
        pslverr:   1'b0
    };

    wortc_regs_s s_q;
    wortc_regs_s s_d;

    logic        osc_tick;
    logic        osc_running;
    logic        osc_cal_busy;
    logic        osc_cal_done;
    logic [1:0]  tmr_phase;
    logic [15:0] wake_period_count;
    logic [7:0]  ctrl_view;
    logic [7:0]  status_view;
    logic        access;
    logic        commit;
    logic        mapped;
    logic [31:0] rd_word;

    // The count is used as one 16-bit value; the two bytes are
    // independent registers, so a period change written byte by byte
    // passes through one intermediate value.
    assign wake_period_count = {s_q.wake_high, s_q.wake_low};

    // Bit 2 is reserved and is never stored.
    assign ctrl_view = {s_q.rc_osc_powerdown, s_q.sec_sel, s_q.rc_osc_calibrate_enable, 1'b0,
                        s_q.res};
    assign status_view = {4'h0, tmr_phase, osc_cal_done, osc_running};

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // The ready flag comes from a flip-flop, so every access phase lasts
    // two cycles: the first raises pready, the second commits.
    assign access = psel && penable;
    assign commit = access && s_q.pready;

    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_WAKE_HIGH:  rd_word = {24'h00_0000, s_q.wake_high};
            ADDR_WAKE_LOW:   rd_word = {24'h00_0000, s_q.wake_low};
            ADDR_TIMER_CTRL: rd_word = {24'h00_0000, ctrl_view};
            ADDR_STATUS:     rd_word = {24'h00_0000, status_view};
            default:         mapped  = 1'b0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.pready  = access && !s_q.pready;
        s_d.pslverr = access && !s_q.pready && !mapped;
        if (access && !s_q.pready) begin
            s_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
        end else if (commit) begin
            s_d.prdata = 32'h0000_0000;
        end
        if (commit && pwrite) begin
            case (paddr)
                ADDR_WAKE_HIGH: begin
                    s_d.wake_high = pwdata[7:0];
                end
                ADDR_WAKE_LOW: begin
                    s_d.wake_low = pwdata[7:0];
                end
                ADDR_TIMER_CTRL: begin
                    s_d.rc_osc_powerdown   = pwdata[CTRL_PD_BIT];
                    s_d.sec_sel = pwdata[CTRL_SEC_LSB +: 3];
                    s_d.rc_osc_calibrate_enable  = pwdata[CTRL_CAL_BIT];
                    s_d.res     = pwdata[CTRL_RES_LSB +: 2];
                end
                default: begin
                    s_d.rc_osc_powerdown = s_q.rc_osc_powerdown;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= REGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;

    // ------------------------------------------------------------------
    // RC oscillator and event timer
    // ------------------------------------------------------------------
    // The timer runs as soon as the oscillator is up; calibration only
    // trims the oscillator and does not hold the timer back.
    wortc_rc_osc u_osc (
        .pclk       (pclk),
        .presetn    (presetn),
        .powerdown  (s_q.rc_osc_powerdown),
        .cal_enable (s_q.rc_osc_calibrate_enable),
        .tick       (osc_tick),
        .running    (osc_running),
        .cal_busy   (osc_cal_busy),
        .cal_done   (osc_cal_done)
    );

    // With the reset count and resolution 0 the interval is 0x876B
    // RC periods, about one second from a 26 MHz reference.
    wortc_event_timer u_tmr (
        .pclk            (pclk),
        .presetn         (presetn),
        .run             (osc_running),
        .tick            (osc_tick),
        .period          (wake_period_count),
        .res             (s_q.res),
        .sec_sel         (s_q.sec_sel),
        .primary_event   (primary_event),
        .secondary_event (secondary_event),
        .phase           (tmr_phase)
    );

    assign rc_osc_running  = osc_running;
    assign rc_osc_cal_busy = osc_cal_busy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wr_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit && pwrite && paddr == ADDR_WAKE_HIGH
        |=> s_q.wake_high == $past(pwdata[7:0]))
        else $error("High wake byte not written");

    wr_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit && pwrite && paddr == ADDR_WAKE_LOW
        |=> s_q.wake_low == $past(pwdata[7:0]) && $stable(s_q.wake_high))
        else $error("Low wake byte not written alone");

    ctrl_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit && pwrite && paddr == ADDR_TIMER_CTRL
        |=> s_q.res == $past(pwdata[1:0])
            && s_q.sec_sel == $past(pwdata[6:4])
            && s_q.rc_osc_calibrate_enable == $past(pwdata[3])
            && s_q.rc_osc_powerdown == $past(pwdata[7]))
        else $error("Control fields not written");

    rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !s_q.pready && !pwrite && paddr == ADDR_TIMER_CTRL
        |=> pready && prdata[2] == 1'b0 && prdata[31:8] == 24'h00_0000)
        else $error("Reserved control bit read non-zero");

    pd_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.rc_osc_powerdown && $past(s_q.rc_osc_powerdown) && $past(s_q.rc_osc_powerdown, 2)
        |-> !rc_osc_running && !primary_event)
        else $error("Timer active while oscillator powered down");

    apb_ans_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 access |=> pready ##1 !pready)
        else $error("APB answer not one cycle into access");

    unmap_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !s_q.pready && !mapped |=> pready && pslverr)
        else $error("Unmapped address not flagged");

endmodule : wortc_top
